/* File: monitor_pkg.sv */
// monitor_pkg: offsets, field positions and carriers of the monitor bank
// assumes: one 10 MHz device clock, 16-bit register reads by byte address
package monitor_pkg;
  // ==========================================================================
  // address map
  localparam logic [7:0] ADDR_RSVD_LOW  = 8'h20;
  localparam logic [7:0] ADDR_STATUS    = 8'h22;
  localparam logic [7:0] ADDR_ALARM     = 8'h24;
  localparam logic [7:0] ADDR_TEMP      = 8'h26;
  localparam logic [7:0] ADDR_SUPPLY    = 8'h28;
  localparam logic [7:0] ADDR_ANALOG    = 8'h2A;
  localparam logic [7:0] ADDR_PULSES    = 8'h2C;
  localparam logic [7:0] ADDR_GAP_FIRST = 8'h2E;
  localparam logic [7:0] ADDR_GAP_LAST  = 8'h3E;
  localparam logic [7:0] ADDR_PHASE     = 8'h40;
  localparam logic [7:0] ADDR_FW_KIND   = 8'h42;
  localparam logic [7:0] ADDR_FW_REV    = 8'h44;
  // ==========================================================================
  // status word bit positions
  localparam int BIT_ALARM     = 0;
  localparam int BIT_HOME      = 1;
  localparam int BIT_PULSE_RDY = 2;
  localparam int BIT_EXCITE    = 3;
  localparam int BIT_OVERHEAT  = 4;
  localparam int BIT_SUPPLY    = 5;
  // ==========================================================================
  // values
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] RSVD_VALUE    = 16'h0000;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;
  localparam logic [15:0] COUNT_ONE     = 16'h0001;
  // arbitrary identification defaults
  localparam logic [15:0] FW_KIND_DEF   = 16'h0001;
  localparam logic [15:0] FW_REV_DEF    = 16'h0064;
  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       main_supply_on;
    logic       overheat;
    logic       excitation_on;
    logic       pulse_ready;
    logic       excitation_home;
    logic       alarm_present;
    logic [7:0] alarm_code_field;
    logic       two_phase;
  } driver_flags_s;
  typedef struct packed {
    logic [15:0] board_temperature;
    logic [15:0] supply_voltage;
    logic [15:0] analog_input_voltage;
  } measures_s;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } reg_req_s;
endpackage : monitor_pkg

/* File: pulse_counter.sv */
// pulse_counter: signed 16-bit wrapping step pulse counter
// assumes: pulse strobes are one-cycle pulses synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module pulse_counter
  import monitor_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // pulse events
  input  wire logic             clockwise,
  input  wire logic             counterclockwise,
  input  wire logic             enable,
  input  wire logic             clear,
  // count
  output logic      [WIDTH-1:0] count
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } state_s;
  state_s state;
  state_s next_state;
  // ==========================================================================
  // next count
  always_comb begin
    next_state = state;
    if (clear) begin
      next_state.count = WIDTH'(COUNT_RESET);
    end else if (enable && clockwise && !counterclockwise) begin
      next_state.count = state.count + WIDTH'(COUNT_ONE);
    end else if (enable && counterclockwise && !clockwise) begin
      next_state.count = state.count - WIDTH'(COUNT_ONE);
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state.count <= WIDTH'(COUNT_RESET);
    end else begin
      state <= next_state;
    end
  end
  assign count = state.count;
endmodule : pulse_counter
`default_nettype wire

/* File: driver_monitor_registers.sv */
// driver_monitor_registers: read-only monitor bank of the motor driver
// assumes: frame engine issues one-cycle requests and sends the word high byte first
`timescale 1ns/1ns
`default_nettype none
module driver_monitor_registers
  import monitor_pkg::*;
#(
  parameter logic [15:0] FW_KIND = FW_KIND_DEF,
  parameter logic [15:0] FW_REV  = FW_REV_DEF
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // register request from frame engine
  input  wire reg_req_s      req,
  output logic               rd_valid,
  output logic               rd_hit,
  output logic        [7:0]  rd_high_byte,
  output logic        [7:0]  rd_low_byte,
  // driver state
  input  wire logic          operating,
  input  wire driver_flags_s flags,
  input  wire measures_s     measures,
  // step pulses
  input  wire logic          clockwise,
  input  wire logic          counterclockwise
);
  typedef enum logic [1:0] {
    ST_SETTING   = 2'b00,
    ST_OPERATION = 2'b01
  } mode_e;
  typedef struct packed {
    mode_e       mode;
    logic        valid;
    logic        hit;
    logic [15:0] word;
  } state_s;
  state_s      state;
  state_s      next_state;
  logic        activate;
  logic [15:0] count;
  // ==========================================================================
  // address decode
  function automatic logic in_bank(input logic [7:0] a);
    in_bank = (a >= ADDR_RSVD_LOW && a <= ADDR_GAP_LAST + 8'h01)
           || (a >= ADDR_PHASE && a <= ADDR_FW_REV + 8'h01);
  endfunction : in_bank
  function automatic logic [15:0] read_word(input logic [7:0] a, input logic [15:0] cnt);
    logic [15:0] w;
    w = RSVD_VALUE;
    case ({a[7:1], 1'b0})
      ADDR_STATUS: begin
        w[BIT_SUPPLY]    = flags.main_supply_on;
        w[BIT_OVERHEAT]  = flags.overheat;
        w[BIT_EXCITE]    = flags.excitation_on;
        w[BIT_PULSE_RDY] = flags.pulse_ready;
        w[BIT_HOME]      = flags.excitation_home;
        w[BIT_ALARM]     = flags.alarm_present;
      end
      ADDR_ALARM:  w = {8'h00, flags.alarm_code_field};
      ADDR_TEMP:   w = measures.board_temperature;
      ADDR_SUPPLY: w = measures.supply_voltage;
      ADDR_ANALOG: w = measures.analog_input_voltage;
      ADDR_PULSES: w = cnt;
      ADDR_PHASE:  w = {15'h0000, flags.two_phase};
      ADDR_FW_KIND: w = FW_KIND;
      ADDR_FW_REV: w = FW_REV;
      default:     w = RSVD_VALUE;
    endcase
    read_word = w;
  endfunction : read_word
  // ==========================================================================
  // state tracking and activation edge
  assign activate = operating && (state.mode == ST_SETTING);
  pulse_counter #(
    .WIDTH            (16)
  ) u_count (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .clockwise        (clockwise),
    .counterclockwise (counterclockwise),
    .enable           (operating && flags.pulse_ready),
    .clear            (activate),
    .count            (count)
  );
  // ==========================================================================
  // read capture
  always_comb begin
    next_state       = state;
    next_state.mode  = operating ? ST_OPERATION : ST_SETTING;
    next_state.valid = 1'b0;
    // reads answered in either mode; writes dropped
    if (req.valid && !req.write) begin
      next_state.valid = 1'b1;
      next_state.hit   = in_bank(req.addr);
      next_state.word  = read_word(req.addr, count);
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state.mode  <= ST_SETTING;
      state.valid <= 1'b0;
      state.hit   <= 1'b0;
      state.word  <= WORD_ZERO;
    end else begin
      state <= next_state;
    end
  end
  // ==========================================================================
  // outputs
  assign rd_valid     = state.valid;
  assign rd_hit       = state.hit;
  assign rd_high_byte = state.word[15:8];
  assign rd_low_byte  = state.word[7:0];
endmodule : driver_monitor_registers
`default_nettype wire

/* File: monitor_sva.sv */
// monitor_sva: port checker for the monitor bank
// assumes: bound onto driver_monitor_registers
`timescale 1ns/1ns
`default_nettype none
module monitor_sva
  import monitor_pkg::*;
(
  // watched ports
  input wire logic          clk,
  input wire logic          sys_rst,
  input wire reg_req_s      req,
  input wire logic          rd_valid,
  input wire logic          rd_hit,
  input wire logic    [7:0] rd_high_byte,
  input wire logic    [7:0] rd_low_byte,
  input wire driver_flags_s flags,
  input wire measures_s     measures
);
  // ==========
  // helpers
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic        rd;
  logic [6:0]  a;
  logic [15:0] w;
  assign rd = req.valid & ~req.write;
  assign a  = req.addr[7:1];
  assign w  = {rd_high_byte, rd_low_byte};
  // ==========
  // checks
  answer_a: assert property (rd |=> rd_valid) else $error("read not answered");
  quiet_a: assert property (!rd |=> !rd_valid) else $error("answer without read");
  map_a: assert property (rd |=> rd_hit == ($past(a) inside {[7'h10:7'h22]}))
    else $error("hit flag wrong");
  status_a: assert property (rd && a == 7'h11 |=> w[5:0] == $past(flags[14:9]))
    else $error("status wrong");
  alarm_a: assert property (rd && a == 7'h12 |=> w[7:0] == $past(flags[8:1]))
    else $error("alarm code wrong");
  temp_a: assert property (rd && a == 7'h13 |=> w == $past(measures[47:32]))
    else $error("temperature wrong");
  supply_a: assert property (rd && a == 7'h14 |=> w == $past(measures[31:16]))
    else $error("supply wrong");
  analog_a: assert property (rd && a == 7'h15 |=> w == $past(measures[15:0]))
    else $error("analog wrong");
  phase_a: assert property (rd && a == 7'h20 |=> w[0] == $past(flags[0]))
    else $error("phase wrong");
endmodule : monitor_sva
`default_nettype wire

/* File: frame_master.sv */
// frame_master: stand-in for the serial master issuing register frames
// assumes: requests change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module frame_master
  import monitor_pkg::*;
(
  // clock
  input wire logic       clk,
  // requests and answers
  output reg_req_s       req,
  output logic           operating,
  input wire logic       rd_valid,
  input wire logic [7:0] rd_high_byte,
  input wire logic [7:0] rd_low_byte
);
  initial begin
    req = '0;
    operating = 1'b0;
  end
  // ==========
  // one-cycle request, word taken high byte first
  task automatic xfer(input logic wr, input logic [7:0] ad, output logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk) req = '{1'b1, wr, ad};
    @(negedge clk) req.valid = 1'b0;
    while (!wr && rd_valid !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    d = {rd_high_byte, rd_low_byte};
  endtask : xfer
  // state frame moves to operation (on = 1) or back to setting (on = 0)
  task automatic set_state(input logic on);
    @(negedge clk) operating = on;
  endtask : set_state
endmodule : frame_master
`default_nettype wire

/* File: tb_top.sv */
// tb_top: self-checking bench for the monitor bank
// assumes: package, design, checker and frame master compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import monitor_pkg::*;
();
  logic          clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          clockwise = 1'b0;
  logic          counterclockwise = 1'b0;
  driver_flags_s flags = '0;
  measures_s     measures = '0;
  reg_req_s      req;
  logic          operating, rd_valid, rd_hit;
  logic [7:0]    rd_high_byte, rd_low_byte;
  logic [15:0]   d;
  int            num_errors = 0;
  int            check_count = 0;
  int            cnt = 0;
  always #50 clk = ~clk;
  driver_monitor_registers u_dut (.clk, .sys_rst, .req, .rd_valid, .rd_hit, .rd_high_byte,
    .rd_low_byte, .operating, .flags, .measures, .clockwise, .counterclockwise);
  frame_master u_m (.clk, .req, .operating, .rd_valid, .rd_high_byte, .rd_low_byte);
  // ==========
  // compare a word under a mask, and a single answer bit
  task automatic word_chk(input string nm, input logic [15:0] e, input logic [15:0] g,
                          input logic [15:0] m);
    check_count++;
    if ((g & m) !== (e & m)) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", nm, e & m, g & m);
    end
  endtask : word_chk
  task automatic bit_chk(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask : bit_chk
  // read one word; answer, hit and masked bits
  task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] e,
                     input logic [15:0] m);
    u_m.xfer(1'b0, a, d);
    bit_chk("rd_valid", 1'b1, rd_valid);
    bit_chk("rd_hit", (a >= 8'h20 && a <= 8'h45), rd_hit);
    word_chk(nm, e, d, m);
  endtask : rdc
  task automatic pulse(input logic cw, input int n);
    repeat (n) begin
      @(negedge clk) {clockwise, counterclockwise} = {cw, ~cw};
      if (operating && flags.pulse_ready) cnt = cnt + (cw ? 1 : -1);
    end
    @(negedge clk) {clockwise, counterclockwise} = 2'b00;
  endtask : pulse
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // ==========
  // tests
  initial begin
    void'($urandom(9971));
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    rdc("count", 8'h2C, 16'h0000, 16'hFFFF);
    for (int i = 0; i < 4; i++) begin
      u_m.set_state(i[0]);
      flags = 15'($urandom);
      measures = 48'({$urandom, $urandom});
      rdc("status", 8'h22, {10'h0, flags[14:9]}, 16'h003F);
      rdc("alarm", 8'h25, {8'h0, flags.alarm_code_field}, 16'h00FF);
      rdc("temp", 8'h26, measures.board_temperature, 16'hFFFF);
      rdc("supply", 8'h28, measures.supply_voltage, 16'hFFFF);
      rdc("analog", 8'h2A, measures.analog_input_voltage, 16'hFFFF);
      rdc("phase", 8'h41, {15'h0, flags.two_phase}, 16'h0001);
      rdc("kind", 8'h42, FW_KIND_DEF, 16'hFFFF);
      rdc("version", 8'h44, FW_REV_DEF, 16'hFFFF);
      rdc("reserved", 8'h3E, RSVD_VALUE, 16'h0000);
    end
    $display("monitor words done");
    u_m.set_state(1'b0);
    flags.pulse_ready = 1'b1;
    pulse(1'b1, 5);
    rdc("version", 8'h44, FW_REV_DEF, 16'hFFFF);
    u_m.xfer(1'b1, 8'h2C, d);
    bit_chk("rd_valid", 1'b0, rd_valid);
    word_chk("kept word", FW_REV_DEF, d, 16'hFFFF);
    rdc("last byte", 8'h45, FW_REV_DEF, 16'hFFFF);
    rdc("low reserved", 8'h20, RSVD_VALUE, 16'h0000);
    rdc("count", 8'h2C, 16'h0000, 16'hFFFF);
    u_m.set_state(1'b1);
    repeat (30) pulse(1'($urandom), 1);
    rdc("count", 8'h2C, cnt[15:0], 16'hFFFF);
    $display("counting done");
    u_m.set_state(1'b0);
    u_m.set_state(1'b1);
    cnt = 0;
    rdc("count", 8'h2C, 16'h0000, 16'hFFFF);
    pulse(1'b0, 32768);
    rdc("count", 8'h2C, cnt[15:0], 16'hFFFF);
    pulse(1'b0, 1);
    rdc("count", 8'h2C, cnt[15:0], 16'hFFFF);
    pulse(1'b1, 1);
    rdc("count", 8'h2C, cnt[15:0], 16'hFFFF);
    $display("wrap done");
    u_m.set_state(1'b0);
    @(negedge clk) sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    cnt = 0;
    rdc("count", 8'h2C, cnt[15:0], 16'hFFFF);
    $display("reset done");
    complete_run();
  end
  initial begin
    #6000000;
    num_errors++;
    complete_run();
  end
endmodule : tb_top
bind driver_monitor_registers monitor_sva u_sva (.clk, .sys_rst, .req, .rd_valid, .rd_hit,
  .rd_high_byte, .rd_low_byte, .flags, .measures);
`default_nettype wire
